// ===== acp_consts.svh
// Constants for the conversion control port.
// Assumes inclusion by bare name from the package and modules.
`ifndef ACP_CONSTS_SVH
`define ACP_CONSTS_SVH
// -----------------------------------------------------------------------
// Conversion timing
// -----------------------------------------------------------------------
`define ACP_RESULT_W 14
`define ACP_CONV_CYCLES 16
`define ACP_CNT_W 5
// Internal oscillator half period in system clocks (125 MHz)
`define ACP_OSC_HALF 9
// Must hold 2 * ACP_OSC_HALF - 1 without truncation
`define ACP_OSC_W 5
`define ACP_RESULT_RST 14'h0000
`endif

// ===== acp_host_model.sv
// Host model: drives start, external conversion clock and bus strobes.
// Assumes callers enter its tasks between rising edges of clk_i.
`timescale 1ns/10ps
`default_nettype none
module acp_host_model
  import acp_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Host pins
  output logic start_o,
  output logic ext_clk_o,
  output acp_bus_ctl_t bus_ctl_o
);
  // ----------------------------------------------------------------
  // Idle levels
  // ----------------------------------------------------------------
  initial
  begin
    start_o = 1'b1;
    ext_clk_o = 1'b0;
    bus_ctl_o = 2'b11;
  end
  // ----------------------------------------------------------------
  // Conversion start; ext clock waits 4 cycles, runs 50/50
  // ----------------------------------------------------------------
  task automatic start(input logic ext);
    int i;
    @(posedge clk_i);
    ext_clk_o <= ext;
    start_o <= 1'b0;
    repeat (4) @(posedge clk_i);
    start_o <= 1'b1;
    // Source level held past the edge; clock starts well after it
    repeat (4) @(posedge clk_i);
    if (ext)
    begin
      for (i = 0; i < 16; i++)
      begin
        ext_clk_o <= 1'b0;
        repeat (20) @(posedge clk_i);
        ext_clk_o <= 1'b1;
        repeat (20) @(posedge clk_i);
      end
      ext_clk_o <= 1'b0;
    end
  endtask
  task automatic read(input acp_bus_ctl_t c);
    @(posedge clk_i);
    bus_ctl_o <= c;
  endtask
endmodule
`default_nettype wire

// ===== acp_pkg.sv
// Types for the conversion control port.
// Assumes acp_consts.svh on the include path.
`include "acp_consts.svh"
package acp_pkg;
  typedef enum logic [3:0] {
    ACP_STANDBY = 4'b0001,
    ACP_IDLE = 4'b0010,
    ACP_CONVERT = 4'b0100,
    ACP_DONE = 4'b1000
  } acp_state_t;

  typedef struct packed {
    logic select_n;
    logic read_n;
  } acp_bus_ctl_t;
endpackage

// ===== acp_port.sv
// Conversion control and readout port of a 14-bit SAR converter.
// Assumes host pins are asynchronous; core result arrives on clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "acp_consts.svh"
module acp_port
  import acp_pkg::*;
#(
  parameter int RESULT_W = `ACP_RESULT_W,
  parameter int CONV_CYCLES = `ACP_CONV_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Host control pins
  input wire logic conversion_start_n_i,
  input wire logic external_conversion_clock_i,
  input wire logic standby_n_i,
  input wire acp_bus_ctl_t bus_ctl_i,
  // Converter core
  input wire logic [RESULT_W-1:0] core_code_i,
  output logic hold_o,
  output logic conv_clk_en_o,
  output logic power_save_o,
  // Host outputs
  output logic [RESULT_W-1:0] result_bus_o,
  output logic result_bus_oe_o,
  output logic busy_o
);
  // Checks below share one clock and reset
  default clocking chk_cb @(posedge clk_i);
  endclocking
  default disable iff (reset_i);

  // -----------------------------------------------------------------------
  // Pin synchronisation
  // -----------------------------------------------------------------------
  logic [4:0] pins_s;
  logic start_s, xclk_s, standby_n_n_s, cs_n_s, rd_n_s;
  logic [2:0] arm_q;
  logic settled;

  acp_sync #(.W(5)) u_sync (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .async_i({conversion_start_n_i, external_conversion_clock_i,
              standby_n_i, bus_ctl_i.select_n, bus_ctl_i.read_n}),
    .sync_o(pins_s)
  );
  // Sync flops reset low, which reads as a pressed active-low pin;
  // pins count as released until three edges load real levels
  assign settled = arm_q[2];
  assign start_s = pins_s[4];
  assign xclk_s = pins_s[3];
  assign standby_n_n_s = pins_s[2] | ~settled;
  assign cs_n_s = pins_s[1] | ~settled;
  assign rd_n_s = pins_s[0] | ~settled;

  // -----------------------------------------------------------------------
  // Edge detection
  // -----------------------------------------------------------------------
  logic start_d1_q, xclk_d1_q;
  logic use_ext_q;
  logic [`ACP_OSC_W-1:0] osc_q;
  logic osc_tick, ext_tick, sel_tick, start_rise;
  logic [`ACP_CNT_W-1:0] cnt_q;
  acp_state_t state_q, state_d;

  assign start_rise = start_s & ~start_d1_q & settled;
  assign ext_tick = xclk_s & ~xclk_d1_q;
  // Free-running oscillator model; divider keeps one clock domain
  assign osc_tick = (osc_q == `ACP_OSC_W'(`ACP_OSC_HALF * 2 - 1));
  assign sel_tick = use_ext_q ? ext_tick : osc_tick;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      arm_q <= '0;
      start_d1_q <= 1'b0;
      xclk_d1_q <= 1'b0;
      osc_q <= '0;
    end
    else
    begin
      arm_q <= {arm_q[1:0], 1'b1};
      start_d1_q <= start_s;
      xclk_d1_q <= xclk_s;
      osc_q <= osc_tick ? '0 : osc_q + 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Conversion sequencer
  // -----------------------------------------------------------------------
  logic last_tick;
  assign last_tick = sel_tick && (cnt_q == `ACP_CNT_W'(CONV_CYCLES - 1));

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ACP_STANDBY: if (standby_n_n_s) state_d = ACP_IDLE;
      ACP_IDLE:
        if (!standby_n_n_s) state_d = ACP_STANDBY;
        else if (start_rise) state_d = ACP_CONVERT;
      ACP_CONVERT: if (last_tick) state_d = ACP_DONE;
      ACP_DONE:
        if (!standby_n_n_s) state_d = ACP_STANDBY;
        else if (start_rise) state_d = ACP_CONVERT;
      default: state_d = ACP_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state_q <= ACP_IDLE;
      cnt_q <= '0;
      use_ext_q <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (state_d == ACP_CONVERT && state_q != ACP_CONVERT)
      begin
        // Clock source latched once; a later change cannot split a sample
        use_ext_q <= xclk_s;
        cnt_q <= '0;
      end
      else if (state_q == ACP_CONVERT && sel_tick)
        cnt_q <= cnt_q + 1'b1;
    end
  end

  // -----------------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------------
  logic selected, read_en;
  assign selected = ~cs_n_s;
  assign read_en = selected & ~rd_n_s;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      result_bus_o <= `ACP_RESULT_RST;
      result_bus_oe_o <= 1'b0;
      busy_o <= 1'b0;
      hold_o <= 1'b0;
      conv_clk_en_o <= 1'b0;
      power_save_o <= 1'b0;
    end
    else
    begin
      // Result changes only at completion
      if (state_q == ACP_CONVERT && last_tick)
        result_bus_o <= core_code_i;
      result_bus_oe_o <= read_en;
      busy_o <= (state_d == ACP_CONVERT);
      hold_o <= (state_d == ACP_CONVERT);
      conv_clk_en_o <= (state_q == ACP_CONVERT) & sel_tick;
      power_save_o <= (state_d == ACP_STANDBY);
    end
  end

  // -----------------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------------
  chk_oe_needs_both: assert property
    (result_bus_oe_o |-> $past(read_en))
    else $error("Bus driven without read and select");
  chk_no_cs_quiet: assert property
    ($past(cs_n_s) |-> !result_bus_oe_o)
    else $error("Bus driven while deselected");
  chk_start_busy: assert property
    ((start_rise && standby_n_n_s && state_q inside {ACP_IDLE, ACP_DONE}) |=>
      (busy_o && hold_o))
    else $error("Start edge did not begin conversion");
  chk_sixteen_ticks: assert property
    ($fell(busy_o) |->
      ($past(cnt_q) == `ACP_CNT_W'(CONV_CYCLES - 1)) &&
      (cnt_q == `ACP_CNT_W'(CONV_CYCLES)))
    else $error("Conversion length wrong");
  chk_src_select: assert property
    ((state_q != ACP_CONVERT && state_d == ACP_CONVERT) |=>
      use_ext_q == $past(xclk_s))
    else $error("Clock source not latched at start");
  chk_ext_clock: assert property
    ((state_q == ACP_CONVERT && use_ext_q) |-> sel_tick == ext_tick)
    else $error("External clock not used");
  chk_int_osc: assert property
    ((state_q == ACP_CONVERT && !use_ext_q) |-> sel_tick == osc_tick)
    else $error("Internal oscillator not used");
  chk_standby: assert property
    ((!standby_n_n_s && state_q != ACP_CONVERT) |=> power_save_o)
    else $error("Standby not entered");
  chk_result_hold: assert property
    (!(state_q == ACP_CONVERT && last_tick) |=> $stable(result_bus_o))
    else $error("Result changed without completion");
  chk_busy_state: assert property
    (busy_o |-> state_q == ACP_CONVERT)
    else $error("Busy outside conversion");

  cov_int_conv: cover property ($fell(busy_o) && !use_ext_q);
  cov_ext_conv: cover property ($fell(busy_o) && use_ext_q);
  cov_read: cover property (state_q == ACP_DONE && result_bus_oe_o);
  cov_standby: cover property ($rose(power_save_o));
  cov_read_no_cs: cover property (cs_n_s && !rd_n_s);
endmodule
`default_nettype wire

// ===== acp_sync.sv
// Two-flop synchroniser bank for asynchronous pins.
// Assumes one destination clock.
`timescale 1ns/10ps
`default_nettype none
module acp_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Data
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);
  logic [W-1:0] meta_q;

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ===== adc_conversion_control_port_tb.sv
// Self-checking bench for the conversion control port.
// Assumes acp_pkg and the host model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control_port_tb
  import acp_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic standby_n = 1'b1;
  logic [13:0] code = 14'h0000;
  logic start, ext_clk, hold, clk_en, psave, oe, busy;
  logic [13:0] result;
  acp_bus_ctl_t bus_ctl;
  int n_mismatch = 0;
  int check_count = 0;
  int ticks = 0;
  int busy_cycles = 0;
  int cyc = 0;
  always #4 clk = ~clk;
  acp_host_model acp_host_model_inst (.clk_i(clk), .start_o(start),
    .ext_clk_o(ext_clk), .bus_ctl_o(bus_ctl));
  acp_port acp_port_inst (.clk_i(clk), .reset_i(reset),
    .conversion_start_n_i(start), .external_conversion_clock_i(ext_clk),
    .standby_n_i(standby_n), .bus_ctl_i(bus_ctl), .core_code_i(code),
    .hold_o(hold), .conv_clk_en_o(clk_en), .power_save_o(psave),
    .result_bus_o(result), .result_bus_oe_o(oe), .busy_o(busy));
  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Hang guard well above the ~1100 cycles the run needs
  always @(posedge clk)
  begin
    cyc++;
    if (clk_en === 1'b1)
      ticks++;
    if (hold === 1'b1 && busy === 1'b1)
      busy_cycles++;
    if (cyc == 3000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic convert(input logic ext, input logic [13:0] c);
    int n;
    n = 0;
    @(posedge clk);
    code <= c;
    #1;
    ticks = 0;
    busy_cycles = 0;
    acp_host_model_inst.start(ext);
    repeat (6) @(posedge clk);
    while (busy !== 1'b0 && n < 1000)
    begin
      @(posedge clk);
      n++;
    end
    @(negedge clk);
    chk(16'(ticks), 16'd16);
    chk({15'h0, hold}, 16'h0);
  endtask
  task automatic read_chk(input logic [13:0] exp);
    acp_host_model_inst.read(2'b00);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk({1'b0, oe, result}, {2'b01, exp});
    acp_host_model_inst.read(2'b11);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({15'h0, oe}, 16'h0);
  endtask
  task automatic t_internal();
    convert(1'b0, 14'h2a5c);
    chk(16'(busy_cycles inside {[270:300]}), 16'h1);
    read_chk(14'h2a5c);
  endtask
  task automatic t_external();
    convert(1'b1, 14'h15a3);
    chk(16'(busy_cycles inside {[600:650]}), 16'h1);
    read_chk(14'h15a3);
  endtask
  // Read without select, then reread after core code moves
  task automatic t_select();
    acp_host_model_inst.read(2'b10);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({15'h0, oe}, 16'h0);
    acp_host_model_inst.read(2'b01);
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({15'h0, oe}, 16'h0);
    acp_host_model_inst.read(2'b11);
    @(posedge clk);
    code <= 14'h3fff;
    read_chk(14'h15a3);
  endtask
  task automatic t_standby();
    @(posedge clk);
    standby_n <= 1'b0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({15'h0, psave}, 16'h1);
    acp_host_model_inst.start(1'b0);
    repeat (30) @(posedge clk);
    @(negedge clk);
    chk({15'h0, busy}, 16'h0);
    @(posedge clk);
    standby_n <= 1'b1;
    repeat (6) @(posedge clk);
    @(negedge clk);
    chk({15'h0, psave}, 16'h0);
  endtask
  // Mid-run reset with start pin idle high must not start a conversion
  task automatic t_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    @(negedge clk);
    chk({13'h0, busy, oe, psave}, 16'h0);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    t_internal();
    t_external();
    t_select();
    t_standby();
    t_reset();
    close_out();
  end
endmodule
`default_nettype wire
